// ### hdl/cds_ctrl.sv
// Clock distribution control: dividers, frame reference path, sync and status pins.
// Assumes clk_i is the distribution clock and a classic Wishbone master.
// How it works
// - Seven device dividers, ratio 1 to 32, 50% duty with correction.
// - Device divider X may feed the paired frame reference output X.
// - One shared frame reference divider, ratio 8 to 8191.
// - Device analog delay 25 ps steps to 575 ps, plus 500 ps.
// - Device digital delay in distribution cycles with half step.
// - New digital delay takes effect only at a sync event.
// - Shared divider delay shifts all frame reference outputs together.
// - Frame analog delay 150 ps steps to 2700 ps, plus 700 ps.
// - Each frame output has local delay 0 to 12 cycles, plus optional half step.
// - Sync resets active outputs to a common edge plus delay.
// - Status pins configurable as input or chosen status output.
// - A divider resets from sync only while its disable bit clear.
// - Mode 0 mux 0 none; mode 1 mux 0 pin or polarity toggle.
// - First reference select zero makes that input the sync input.
// - Mode 2 mux 2: each pin transition fires a burst.
// - Mode 3 mux 2: writing pulse count fires a burst.
// - Mode 1 mux 1: sync realigned to the frame divider.
// - Request mode streams pulses while pin asserted, no runts.
// - Bursts hold 1, 2, 4 or 8 pulses.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module cds_ctrl
  import cds_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          sync_pin_i,
  input  wire logic          first_ref_i,
  input  wire logic          los_i,
  input  wire logic          lock_i,
  input  wire logic          lock2_i,
  input  wire logic          vtune_alarm_i,
  input  wire logic [3:0]    stat_pin_i,
  output logic      [3:0]    stat_pin_o,
  output logic      [3:0]    stat_pin_oe_o,
  output logic      [1:0]    ref_select_o,
  output logic [NDIV-1:0]    device_clock_output_o,
  output logic [NDIV-1:0]    frame_ref_clock_output_o,
  output logic [NDIV*11-1:0] dclk_adly_ps_o,
  output logic [NDIV*12-1:0] fref_adly_ps_o
);
  logic [31:0]     ctrl_r, dis_r, pulse_r, sdiv_r, pincfg_r;
  logic [31:0]     dcfg_r [NDIV];
  logic [31:0]     fcfg_r [NDIV];
  logic            ack_r;
  logic [5:0]      s1_r, s2_r, s3_r, flt_r;
  logic            lvl, lvl_d_r, lvl_edge, lvl_rise;
  logic            sync_evt, resync_r, div_sync;
  logic [NDIV:0]   dsync;
  logic [NDIV-1:0] dclk;
  logic [NDIV-1:0] fref_loc;
  logic            sdiv_clk, sdiv_rise, sclk_d_r;
  logic            gate_r, start, busy;
  logic [3:0]      left_r;
  logic            fref_sig;
  logic [SRW-1:0]  sr_r [NDIV];
  logic [NDIV-1:0] hsn_r;
  logic            wr, pulse_wr;
  logic [1:0]      mode, mux;

  assign mode = ctrl_r[C_MODE +: 2];
  assign mux  = ctrl_r[C_MUX +: 2];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  function automatic logic [4:0] clampc(input logic [4:0] c, input logic [4:0] m);
    return (c > m) ? m : c;
  endfunction

  // ************
  // Wishbone slave
  // ************
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign pulse_wr = wr && wb_adr_i == OFS_PULSE;
  assign wb_ack_o = ack_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r   <= RST_CTRL;
      dis_r    <= 32'h0;
      pulse_r  <= 32'h0;
      sdiv_r   <= RST_SDIV;
      pincfg_r <= 32'h0;
      for (int k = 0; k < NDIV; k++)
      begin
        dcfg_r[k] <= RST_DCFG;
        fcfg_r[k] <= RST_FCFG;
      end
    end
    else if (wr)
    begin
      case (wb_adr_i)
        OFS_CTRL:   ctrl_r   <= merge(ctrl_r, wb_dat_i, wb_sel_i);
        OFS_DIS:    dis_r    <= merge(dis_r, wb_dat_i, wb_sel_i);
        OFS_PULSE:  pulse_r  <= merge(pulse_r, wb_dat_i, wb_sel_i);
        OFS_SDIV:   sdiv_r   <= merge(sdiv_r, wb_dat_i, wb_sel_i);
        OFS_PINCFG: pincfg_r <= merge(pincfg_r, wb_dat_i, wb_sel_i);
        default:
        begin
          for (int k = 0; k < NDIV; k++)
          begin
            if (wb_adr_i == OFS_DCFG + 8'(4 * k))
              dcfg_r[k] <= merge(dcfg_r[k], wb_dat_i, wb_sel_i);
            if (wb_adr_i == OFS_FCFG + 8'(4 * k))
              fcfg_r[k] <= merge(fcfg_r[k], wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else
    begin
      case (wb_adr_i)
        OFS_CTRL:   wb_dat_o <= ctrl_r;
        OFS_DIS:    wb_dat_o <= {24'h0, dis_r[7:0]};
        OFS_PULSE:  wb_dat_o <= {30'h0, pulse_r[1:0]};
        OFS_SDIV:   wb_dat_o <= {13'h0, sdiv_r[18:0]};
        OFS_STAT:   wb_dat_o <= {24'h0, flt_r[1:0], left_r, gate_r, busy};
        OFS_PINCFG: wb_dat_o <= {20'h0, pincfg_r[11:0]};
        default:
        begin
          wb_dat_o <= 32'h0;
          for (int k = 0; k < NDIV; k++)
          begin
            if (wb_adr_i == OFS_DCFG + 8'(4 * k))
              wb_dat_o <= {11'h0, dcfg_r[k][20:0]};
            if (wb_adr_i == OFS_FCFG + 8'(4 * k))
              wb_dat_o <= {20'h0, fcfg_r[k][11:0]};
          end
        end
      endcase
    end
  end

  // ************
  // Pin synchronisers
  // ************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r  <= 6'h0;
      s2_r  <= 6'h0;
      s3_r  <= 6'h0;
      flt_r <= 6'h0;
    end
    else
    begin
      s1_r <= {stat_pin_i, first_ref_i, sync_pin_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 6; i++)
        if (s2_r[i] == s3_r[i])
          flt_r[i] <= s3_r[i];
    end
  end

  // ************
  // Sync source
  // ************
  assign lvl = (ctrl_r[C_REFSEL +: 2] == 2'h0 && mode < 2'h2 && mux < 2'h2) ?
               flt_r[1] : (flt_r[0] ^ ctrl_r[C_POL]);
  assign lvl_edge = lvl ^ lvl_d_r;
  assign lvl_rise = lvl & ~lvl_d_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lvl_d_r <= 1'b0;
    else
      lvl_d_r <= lvl;
  end

  always_comb
  begin
    sync_evt = 1'b0;
    if (ctrl_r[C_REFSEL +: 2] == 2'h0 && mode < 2'h2 && mux < 2'h2)
      sync_evt = (mux == 2'h0) ? lvl_rise : resync_r & sdiv_rise;
    else if (mode == 2'h1 && mux == 2'h0)
      sync_evt = lvl_rise;
    else if (mode == 2'h1 && mux == 2'h1)
      sync_evt = resync_r & sdiv_rise;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      resync_r <= 1'b0;
    else if (lvl_rise && mux == 2'h1)
      resync_r <= 1'b1;
    else if (sdiv_rise)
      resync_r <= 1'b0;
  end

  assign div_sync = sync_evt & ctrl_r[C_SYNC_EN];
  for (genvar k = 0; k <= NDIV; k++)
  begin : g_ds
    assign dsync[k] = div_sync & ~dis_r[k];
  end

  // ************
  // Dividers
  // ************
  for (genvar k = 0; k < NDIV; k++)
  begin : g_div
    cds_div u_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ratio_i ((dcfg_r[k][D_RATIO +: 5] == 5'h0) ? 13'h20 : {8'h0, dcfg_r[k][D_RATIO +: 5]}),
      .dly_i   (dcfg_r[k][D_DLYPD] ? 6'h0 : dcfg_r[k][D_DLY +: DW]),
      .hs_i    (dcfg_r[k][D_HS]),
      .dcc_i   (dcfg_r[k][D_DCC]),
      .sync_i  (dsync[k]),
      .clk_o   (dclk[k]),
      .rise_o  ()
    );
    assign device_clock_output_o[k] = dclk[k];
    assign dclk_adly_ps_o[11*k +: 11] = dcfg_r[k][D_AEN] ? 11'(DA_OFS_PS + DA_STEP_PS *
      clampc(dcfg_r[k][D_ADLY +: 5], 5'(DA_MAXCODE))) : 11'h0;
    assign fref_adly_ps_o[12*k +: 12] = fcfg_r[k][F_AEN] ? 12'(FA_OFS_PS + FA_BASE_PS +
      FA_STEP_PS * clampc({1'b0, fcfg_r[k][F_ADLY +: 4]}, 5'(FA_MAXCODE))) : 12'h0;
  end

  cds_div u_sdiv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (sdiv_r[RW-1:0]),
    .dly_i   (ctrl_r[C_GDLY_PD] ? 6'h0 : sdiv_r[RW +: DW]),
    .hs_i    (1'b0),
    .dcc_i   (1'b1),
    .sync_i  (dsync[NDIV]),
    .clk_o   (sdiv_clk),
    .rise_o  (sdiv_rise)
  );

  // ************
  // Pulser and request gate
  // ************
  assign start = mux == 2'h2 && !ctrl_r[C_PLS_PD] &&
                 ((mode == 2'h2 && lvl_edge) || (mode == 2'h3 && pulse_wr));
  assign busy  = left_r != 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      left_r <= 4'h0;
    else if (start)
      left_r <= 4'h1 << (mode == 2'h3 ? wb_dat_i[1:0] : pulse_r[1:0]);
    else if (sdiv_rise && busy && !gate_r)
      left_r <= left_r;
    else if (sdiv_rise && busy)
      left_r <= left_r - 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gate_r <= 1'b0;
    else if (sdiv_rise)
    begin
      if (mode == 2'h0 && ctrl_r[C_REQ_EN])
        gate_r <= flt_r[0] ^ ctrl_r[C_POL];
      else
        gate_r <= busy && !(gate_r && left_r == 4'h1);
    end
  end

  // Gate moves with the delayed clock edge, so no runt pulse appears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sdiv_clk;
  end

  always_comb
  begin
    case (mux)
      2'h2:    fref_sig = gate_r & sclk_d_r;
      2'h3:    fref_sig = sdiv_clk;
      default: fref_sig = lvl;
    endcase
    if (ctrl_r[C_BLK_PD])
      fref_sig = 1'b0;
  end

  // ************
  // Local delay and frame outputs
  // ************
  always_ff @(posedge clk_i)
  begin
    for (int k = 0; k < NDIV; k++)
    begin
      if (rst_i || ctrl_r[C_LCLR])
        sr_r[k] <= 12'h0;
      else
        sr_r[k] <= {sr_r[k][SRW-2:0], fref_sig};
    end
  end

  always_comb
  begin
    for (int k = 0; k < NDIV; k++)
      fref_loc[k] = (fcfg_r[k][F_LDLY +: 4] == 4'h0) ? fref_sig :
                    (fcfg_r[k][F_LDLY +: 4] > 4'(SRW)) ? sr_r[k][SRW-1] :
                    sr_r[k][fcfg_r[k][F_LDLY +: 4] - 4'h1];
  end

  always_ff @(negedge clk_i)
  begin
    if (rst_i)
      hsn_r <= 7'h0;
    else
      hsn_r <= fref_loc;
  end

  for (genvar k = 0; k < NDIV; k++)
  begin : g_fo
    logic src;
    assign src = fcfg_r[k][F_SEL] ? (fcfg_r[k][F_HS] ? hsn_r[k] : fref_loc[k])
                                  : dclk[k];
    assign frame_ref_clock_output_o[k] = ~fcfg_r[k][F_PD] & src;
  end

  // ************
  // Status pins
  // ************
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (rst_i)
      begin
        stat_pin_o[i]    <= 1'b0;
        stat_pin_oe_o[i] <= 1'b0;
      end
      else
      begin
        stat_pin_oe_o[i] <= pincfg_r[3*i +: 3] != CDS_PIN_IN;
        case (pincfg_r[3*i +: 3])
          CDS_PIN_LOS:   stat_pin_o[i] <= los_i;
          CDS_PIN_LOCK:  stat_pin_o[i] <= lock_i & lock2_i;
          CDS_PIN_LOCK2: stat_pin_o[i] <= lock2_i;
          CDS_PIN_DIV:   stat_pin_o[i] <= sdiv_clk;
          CDS_PIN_RDBK:  stat_pin_o[i] <= busy;
          CDS_PIN_VTUNE: stat_pin_o[i] <= vtune_alarm_i;
          default:       stat_pin_o[i] <= 1'b0;
        endcase
      end
    end
  end

  assign ref_select_o = {pincfg_r[5:3] == CDS_PIN_IN ? flt_r[3] : 1'b0,
                         pincfg_r[2:0] == CDS_PIN_IN ? flt_r[2] : 1'b0};

  // ************
  // Checks
  // ************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pin_up;
    mode == 2'h1 && mux == 2'h0 && ctrl_r[C_SYNC_EN] && !ctrl_r[C_POL] && ctrl_r[13:12] != 2'h0
      && $rose(sync_pin_i) && !flt_r[0];
  endsequence
  sequence s_pin_held;
    sync_pin_i[*4];
  endsequence

  property p_pin_sync;
    s_pin_up ##0 s_pin_held |-> ##[0:2] div_sync;
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin did not sync");

  property p_en;
    !ctrl_r[C_SYNC_EN] |-> dsync == 8'h0;
  endproperty
  a_en: assert property (p_en) else $error("sync while disabled");

  property p_dis;
    dis_r[0] |-> !dsync[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled divider synced");

  property p_off;
    mode == 2'h0 && mux == 2'h0 && ctrl_r[13:12] != 2'h0 |-> !sync_evt;
  endproperty
  a_off: assert property (p_off) else $error("sync in disabled mode");

  property p_pol;
    mode == 2'h1 && mux == 2'h0 && ctrl_r[13:12] != 2'h0 && $rose(ctrl_r[C_POL]) && !flt_r[0]
      && $stable(flt_r[0]) |-> sync_evt;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity toggle no sync");

  property p_cont;
    mux == 2'h3 && !ctrl_r[C_BLK_PD] |-> fref_sig == sdiv_clk;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous path wrong");

  property p_count;
    start && mode == 2'h2 |=> left_r == (4'h1 << $past(pulse_r[1:0]));
  endproperty
  a_count: assert property (p_count) else $error("burst count wrong");

  property p_spi_start;
    pulse_wr && mode == 2'h3 && mux == 2'h2 && !ctrl_r[C_PLS_PD] |=> busy;
  endproperty
  a_spi_start: assert property (p_spi_start) else $error("write did not fire burst");

  property p_clr;
    ctrl_r[C_LCLR] |=> sr_r[0] == 12'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("local delay not cleared");
endmodule

// ### hdl/cds_pkg.sv
// Shared constants for the clock distribution sync and frame reference control.
// Assumes a 32-bit classic Wishbone register port and one distribution clock.
package cds_pkg;
  // ************
  // Sizes
  // ************
  localparam int NDIV    = 7;
  localparam int RW      = 13;
  localparam int DW      = 6;
  localparam int SRW     = 12;
  // ************
  // Register byte offsets
  // ************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DIS    = 8'h04;
  localparam logic [7:0] OFS_PULSE  = 8'h08;
  localparam logic [7:0] OFS_SDIV   = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_PINCFG = 8'h14;
  localparam logic [7:0] OFS_DCFG   = 8'h20;
  localparam logic [7:0] OFS_FCFG   = 8'h40;
  // ************
  // Control fields
  // ************
  localparam int C_SYNC_EN = 0;
  localparam int C_POL     = 1;
  localparam int C_MODE    = 2;
  localparam int C_MUX     = 4;
  localparam int C_REQ_EN  = 6;
  localparam int C_BLK_PD  = 7;
  localparam int C_PLS_PD  = 8;
  localparam int C_GDLY_PD = 9;
  localparam int C_LCLR    = 10;
  localparam int C_REFSEL  = 12;
  // ************
  // Device clock config fields
  // ************
  localparam int D_RATIO = 0;
  localparam int D_DLY   = 5;
  localparam int D_HS    = 11;
  localparam int D_DCC   = 12;
  localparam int D_DLYPD = 13;
  localparam int D_ADLY  = 15;
  localparam int D_AEN   = 20;
  // ************
  // Frame reference output fields
  // ************
  localparam int F_PD   = 0;
  localparam int F_SEL  = 1;
  localparam int F_LDLY = 2;
  localparam int F_HS   = 6;
  localparam int F_ADLY = 7;
  localparam int F_AEN  = 11;
  // ************
  // Reset values
  // ************
  localparam logic [31:0] RST_CTRL = 32'h0000_1780;
  localparam logic [31:0] RST_DCFG = 32'h0000_3002;
  localparam logic [31:0] RST_FCFG = 32'h0000_0001;
  localparam logic [31:0] RST_SDIV = 32'h0000_0008;
  // ************
  // Analog delay figures in ps, and code limits
  // ************
  localparam int DA_STEP_PS = 25;
  localparam int DA_MAXCODE = 23;
  localparam int DA_OFS_PS  = 500;
  localparam int FA_STEP_PS = 150;
  localparam int FA_MAXCODE = 14;
  localparam int FA_BASE_PS = 600;
  localparam int FA_OFS_PS  = 700;
  // ************
  // Status pin selections
  // ************
  typedef enum logic [2:0] {
    CDS_PIN_IN = 3'h0, CDS_PIN_LOS = 3'h1, CDS_PIN_LOCK = 3'h2, CDS_PIN_LOCK2 = 3'h3,
    CDS_PIN_DIV = 3'h4, CDS_PIN_RDBK = 3'h5, CDS_PIN_VTUNE = 3'h6
  } cds_pin_e;
endpackage

// ### hdl/cds_div.sv
// Divider with sync reset, digital delay, half step and duty cycle correction.
// Assumes ratio and delay are steady software settings on the same clock.
`timescale 1ns/1ps
module cds_div
  import cds_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [RW-1:0] ratio_i,
  input  wire logic [DW-1:0] dly_i,
  input  wire logic          hs_i,
  input  wire logic          dcc_i,
  input  wire logic          sync_i,
  output logic               clk_o,
  output logic               rise_o
);
  logic [RW-1:0] cnt_r;
  logic [DW-1:0] wait_r;
  logic          hs_r;
  logic          pos_r;
  logic          pos_d_r;
  logic          neg_r;
  logic          out_n_r;
  logic [RW-1:0] hi;
  logic          shaped;

  assign hi     = dcc_i ? RW'((ratio_i + 13'h1) >> 1) : (ratio_i >> 1);
  assign shaped = (dcc_i && ratio_i[0] && ratio_i != 13'h1) ? (pos_r & neg_r) : pos_r;
  assign clk_o  = hs_r ? out_n_r : shaped;
  assign rise_o = pos_r & ~pos_d_r;

  // ************
  // Count and delay
  // ************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= 13'h0;
      wait_r <= 6'h0;
      hs_r   <= 1'b0;
      pos_r  <= 1'b0;
    end
    else if (sync_i)
    begin
      cnt_r  <= 13'h0;
      wait_r <= dly_i;
      hs_r   <= hs_i;
      pos_r  <= 1'b0;
    end
    else if (wait_r != 6'h0)
      wait_r <= wait_r - 6'h1;
    else
    begin
      cnt_r <= (cnt_r + 13'h1 >= ratio_i) ? 13'h0 : cnt_r + 13'h1;
      pos_r <= (cnt_r < hi) || (ratio_i < 13'h2);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos_d_r <= 1'b0;
    else
      pos_d_r <= pos_r;
  end

  // ************
  // Half cycle stage
  // ************
  always_ff @(negedge clk_i)
  begin
    if (rst_i)
    begin
      neg_r   <= 1'b0;
      out_n_r <= 1'b0;
    end
    else
    begin
      neg_r   <= pos_r;
      out_n_r <= shaped;
    end
  end
endmodule

// ### verification/cds_rx_model.sv
// Receiver model: counts frame reference output 1 pulses and times device clock 0.
// Assumes a 10 ns distribution clock when turning time into cycles.
`timescale 1ns/1ps
module cds_rx_model
(
  input  wire logic [6:0] dco_i,
  input  wire logic [6:0] fro_i,
  output int              fr_cnt_o,
  output int              dc_per_o
);
  time last_t = 0;
  initial fr_cnt_o = 0;
  initial dc_per_o = 0;
  // ************
  // Edge counting
  // ************
  always @(posedge fro_i[1]) fr_cnt_o <= fr_cnt_o + 1;
  always @(posedge dco_i[0])
  begin
    dc_per_o <= int'(($time - last_t) / 10);
    last_t = $time;
  end
endmodule

// ### verification/cds_ctrl_tb.sv
// Testbench for the clock distribution control block.
// Assumes the receiver model on the clock outputs; the bench is the Wishbone master.
`timescale 1ns/1ps
module cds_ctrl_tb;
  import cds_pkg::*;
  logic            clk_i = 0;
  logic            rst_i = 1;
  logic            cyc = 0, stb = 0, we = 0, wb_ack_o;
  logic [7:0]      adr = 8'h00;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     dat = 32'h0, wb_dat_o, v, exp_d;
  logic [31:0]     seed = 32'h13066E01;
  logic            sync_pin = 0, first_ref = 0, los = 0, lock = 0, lock2 = 0, vt = 0, e;
  logic [3:0]      ext_pin = 4'hA, pin_o, pin_oe, pin_w;
  logic [NDIV-1:0] dco, fro;
  logic [NDIV*11-1:0] dadly;
  logic [NDIV*12-1:0] fadly;
  logic [1:0]      rsel;
  logic [4:0]      rat[4] = '{5'h02, 5'h03, 5'h07, 5'h00};
  logic [2:0]      psel[4] = '{3'h1, 3'h2, 3'h3, 3'h6};
  int              n_errors = 0, checks = 0, fr_cnt, dc_per, c0;
  logic [31:0]     expq[$];
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & ext_pin);
  cds_ctrl i_cds_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sync_pin_i(sync_pin), .first_ref_i(first_ref), .los_i(los), .lock_i(lock), .lock2_i(lock2),
    .vtune_alarm_i(vt), .stat_pin_i(pin_w), .stat_pin_o(pin_o), .stat_pin_oe_o(pin_oe), .ref_select_o(rsel),
    .device_clock_output_o(dco), .frame_ref_clock_output_o(fro), .dclk_adly_ps_o(dadly), .fref_adly_ps_o(fadly));
  cds_rx_model i_cds_rx_model (.dco_i(dco), .fro_i(fro), .fr_cnt_o(fr_cnt), .dc_per_o(dc_per));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  // ************
  // Helpers
  // ************
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      chk(1'b0, "no bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cnt(input int w, input int lo, input int hi, input string m);
    pause(10);
    c0 = fr_cnt;
    pause(w);
    chk((fr_cnt - c0) >= lo && (fr_cnt - c0) <= hi, m);
  endtask
  // ************
  // Read result monitor
  // ************
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && we === 1'b0)
    begin
      if (expq.size() == 0)
        chk(1'b0, "read answer without request");
      else
      begin
        exp_d = expq.pop_front();
        chk(wb_dat_o === exp_d, "read data");
      end
    end
  end
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
  // ************
  // Scenarios
  // ************
  initial
  begin
    pause(20);
    rst_i <= 1'b0;
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_SDIV, RST_SDIV);
    rd(OFS_DCFG, RST_DCFG);
    rd(OFS_FCFG, RST_FCFG);
    rd(8'hFC, 32'h0);
    v = xs() & 32'hFF;
    wb(1'b1, OFS_DIS, v);
    rd(OFS_DIS, v);
    wb(1'b1, OFS_DIS, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0000_1405);
    pause(15);
    wb(1'b1, OFS_CTRL, 32'h0000_1005);
    foreach (rat[i])
    begin
      wb(1'b1, OFS_DCFG, 32'h0000_1000 | rat[i]);
      wb(1'b1, OFS_CTRL, 32'h0000_1007);
      wb(1'b1, OFS_CTRL, 32'h0000_1005);
      pause(120);
      chk(dc_per == ((rat[i] == 5'h00) ? 32 : int'(rat[i])), "divider period");
    end
    sync_pin <= 1'b1;
    pause(80);
    chk(dc_per == 32, "pin sync period");
    sync_pin <= 1'b0;
    pause(10);
    wb(1'b1, OFS_DCFG + 8'h08, 32'h0010_0000 | (32'h1F << D_ADLY));
    pause(2);
    chk(dadly[22 +: 11] === 11'(DA_OFS_PS + DA_STEP_PS * DA_MAXCODE), "device analog clamp");
    wb(1'b1, OFS_DCFG + 8'h08, 32'h0010_0000 | (32'h4 << D_ADLY));
    pause(2);
    chk(dadly[22 +: 11] === 11'(DA_OFS_PS + DA_STEP_PS * 4), "device analog delay");
    wb(1'b1, OFS_FCFG + 8'h08, 32'h0000_0F81);
    pause(2);
    chk(fadly[24 +: 12] === 12'(FA_OFS_PS + FA_BASE_PS + FA_STEP_PS * FA_MAXCODE), "frame analog");
    wb(1'b1, OFS_DCFG + 8'h04, 32'h0000_1004);
    wb(1'b1, OFS_FCFG + 8'h04, 32'h0);
    cnt(100, 24, 26, "paired output");
    wb(1'b1, OFS_FCFG + 8'h04, 32'h2);
    wb(1'b1, OFS_CTRL, 32'h0000_102D);
    for (int k = 0; k < 4; k++)
    begin
      c0 = fr_cnt;
      wb(1'b1, OFS_PULSE, k);
      pause(250);
      chk(fr_cnt - c0 == (1 << k), "burst length");
    end
    wb(1'b1, OFS_CTRL, 32'h0000_1029);
    pause(30);
    c0 = fr_cnt;
    sync_pin <= 1'b1;
    pause(250);
    chk(fr_cnt - c0 == 8, "pin burst");
    sync_pin <= 1'b0;
    pause(250);
    wb(1'b1, OFS_CTRL, 32'h0000_1161);
    sync_pin <= 1'b1;
    cnt(160, 19, 21, "request stream");
    sync_pin <= 1'b0;
    pause(30);
    cnt(100, 0, 0, "request stopped");
    wb(1'b1, OFS_CTRL, 32'h0000_1131);
    cnt(400, 49, 51, "continuous output");
    foreach (psel[i])
    begin
      wb(1'b1, OFS_PINCFG, {29'h0, psel[i]});
      v = xs();
      @(posedge clk_i);
      {los, lock, lock2, vt} <= v[3:0];
      e = (psel[i] == 3'h1) ? v[3] : (psel[i] == 3'h2) ? (v[2] & v[1]) : (psel[i] == 3'h3) ? v[1] : v[0];
      pause(5);
      chk(pin_oe[0] === 1'b1 && pin_o[0] === e, "status pin");
    end
    wb(1'b1, OFS_PINCFG, 32'h0);
    pause(6);
    chk(pin_oe[0] === 1'b0, "status pin input");
    chk(rsel === 2'b10, "ref select input");
    stop_test();
  end
endmodule
